// ### common/scb_regs_pkg.sv
// Constants for the system control register bank: offsets, fields, keys.
// Assumes a 32-bit word bus with byte addresses and a single clock.
//
// Behaviour
// - Bit 22 flags any pending external interrupt.
// - Bits 17:12 give highest pending enabled number.
// - Bits 5:0 give active number, zero in thread.
// - Active number equals interrupt line index plus 16.
// - Active field mirrors the status word's low bits.
// - Reset control writes need key 0x05fa above.
// - Bit 15 reports byte order, read only.
// - Keyed write of bit 2 requests system reset.
// - Bit 1 is debug only and reads zero.
// - Bit 4 lets disabled interrupts wake too.
// - New pending wakes wait, else is latched.
// - Send event instruction also wakes the waiter.
// - Bit 2 selects sleep or deep sleep.
// - Bit 1 sleeps on return to thread mode.
// - Write 1 sets tick pending; reads show it.
// - Write 1 clears deferred service pending.

package scb_regs_pkg;

    // ****************************************************************
    // Register map.
    // ****************************************************************
    localparam int          ADDR_W          = 5;
    localparam logic [4:0]  OFS_INT_CTRL    = 5'h04;
    localparam logic [4:0]  OFS_RST_CTRL    = 5'h0c;
    localparam logic [4:0]  OFS_SLEEP_CTRL  = 5'h10;

    // ****************************************************************
    // Field positions.
    // ****************************************************************
    localparam int          B_DS_SET        = 28;
    localparam int          B_DS_CLR        = 27;
    localparam int          B_TICK_SET      = 26;
    localparam int          B_TICK_CLR      = 25;
    localparam int          B_ANY_PEND      = 22;
    localparam int          B_HIGH_LO       = 12;
    localparam int          B_KEY_LO        = 16;
    localparam int          B_BYTE_ORDER    = 15;
    localparam int          B_SYS_RESET     = 2;
    localparam int          B_WAKE_ANY      = 4;
    localparam int          B_DEEP          = 2;
    localparam int          B_SLEEP_EXIT    = 1;

    localparam logic [15:0] WRITE_KEY       = 16'h05fa;

    // ****************************************************************
    // Exception numbering and reset values.
    // ****************************************************************
    localparam int          NUM_IRQ         = 32;
    localparam logic [5:0]  IRQ_BASE        = 6'h10;
    localparam logic [5:0]  EXC_DEFERRED    = 6'h0e;
    localparam logic [5:0]  EXC_TICK        = 6'h0f;
    localparam logic [2:0]  SLEEP_CTRL_RST  = 3'h0;

endpackage

// ### dv/scb_regs_props.sv
// Checker for the system control register bank, watching its ports only.
// Assumes a single clock and the synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none

module scb_regs_props (
    // Clock and reset.
    input wire logic        clk,
    input wire logic        rstn,
    // Bus.
    input wire logic [4:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] writedata,
    input wire logic [3:0]  byteenable,
    input wire logic        waitrequest,
    // Core side.
    input wire logic [31:0] irq_pending,
    input wire logic [31:0] irq_enable,
    input wire logic        wait_for_event_instr,
    input wire logic        send_event_instr,
    input wire logic        handler_return,
    input wire logic        any_irq_pending,
    input wire logic [5:0]  highest_pending_number,
    input wire logic        system_reset_request,
    input wire logic        sleep_after_handler_return,
    input wire logic        wake_on_any_pending,
    input wire logic        processor_wake,
    input wire logic        waiting_for_event,
    input wire logic        sleep_request
);
    // ****
    // Properties.
    // ****
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_bus_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("request not answered");
    a_bus_release: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest held low");
    a_any_pending: assert property ($past(rstn) |-> any_irq_pending == |$past(irq_pending))
        else $error("pending flag wrong");
    a_highest_range: assert property (highest_pending_number == 6'h00 ||
        (highest_pending_number >= 6'h0e && highest_pending_number < 6'h30))
        else $error("highest pending number out of range");
    a_reset_keyed: assert property (system_reset_request |-> $past(write && !waitrequest &&
        address == scb_regs_pkg::OFS_RST_CTRL && byteenable == 4'hf && writedata[2] &&
        writedata[31:16] == scb_regs_pkg::WRITE_KEY))
        else $error("unkeyed reset request");
    a_reset_pulse: assert property (system_reset_request |=> !system_reset_request)
        else $error("reset request too long");
    a_exit_sleep: assert property (handler_return |=>
        sleep_request == $past(sleep_after_handler_return))
        else $error("sleep on exit wrong");
    a_sev_wake: assert property (waiting_for_event && send_event_instr |=> processor_wake)
        else $error("send event did not wake");
    a_irq_wake: assert property ($past(rstn) && waiting_for_event &&
        |(irq_pending & ~$past(irq_pending) & (irq_enable | {32{wake_on_any_pending}}))
        |=> processor_wake)
        else $error("interrupt did not wake");
    a_wake_cause: assert property (processor_wake |->
        $past(waiting_for_event || wait_for_event_instr))
        else $error("wake without a wait");

    c_reset: cover property (system_reset_request);
    c_sleep: cover property (sleep_request);
    c_wake_any: cover property (processor_wake && wake_on_any_pending);
endmodule

bind system_control_block_regs scb_regs_props chk (
    .clk(clk), .rstn(rstn), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .waitrequest(waitrequest),
    .irq_pending(irq_pending), .irq_enable(irq_enable),
    .wait_for_event_instr(wait_for_event_instr), .send_event_instr(send_event_instr),
    .handler_return(handler_return), .any_irq_pending(any_irq_pending),
    .highest_pending_number(highest_pending_number),
    .system_reset_request(system_reset_request),
    .sleep_after_handler_return(sleep_after_handler_return),
    .wake_on_any_pending(wake_on_any_pending), .processor_wake(processor_wake),
    .waiting_for_event(waiting_for_event), .sleep_request(sleep_request));

`default_nettype wire

// ### dv/system_control_block_regs_tb.sv
// Self-checking bench for the system control register bank.
// Assumes the bank and its package are compiled first.
`timescale 1ns/10ps
`default_nettype none

module system_control_block_regs_tb;
    localparam logic [4:0] IC = scb_regs_pkg::OFS_INT_CTRL;
    localparam logic [4:0] RC = scb_regs_pkg::OFS_RST_CTRL;
    localparam logic [4:0] SC = scb_regs_pkg::OFS_SLEEP_CTRL;
    logic clk, rstn, read, write, waitrequest, big_endian;
    logic [4:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata, readdata, irq_pending, irq_enable, q;
    logic [63:0] irq_prio;
    logic [1:0] tick_prio, ds_prio;
    logic [5:0] ips, strb, hpn;
    logic tk_p, ds_p, any_p, srr, deep, soe, woa, wake, waiting, slp;
    int num_errors, total_checks;

    // ****
    // Clock, stimulus defaults and design.
    // ****
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    system_control_block_regs uut (
        .clk(clk), .rstn(rstn), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .irq_pending(irq_pending), .irq_enable(irq_enable),
        .irq_prio(irq_prio), .tick_prio(tick_prio), .ds_prio(ds_prio),
        .interrupt_program_status(ips), .big_endian(big_endian),
        .tick_event(strb[0]), .tick_taken(strb[1]), .ds_taken(strb[2]),
        .wait_for_event_instr(strb[3]), .send_event_instr(strb[4]),
        .handler_return(strb[5]), .tick_pending(tk_p), .ds_pending(ds_p),
        .highest_pending_number(hpn), .any_irq_pending(any_p),
        .system_reset_request(srr), .deep_low_power_select(deep),
        .sleep_after_handler_return(soe), .wake_on_any_pending(woa),
        .processor_wake(wake), .waiting_for_event(waiting), .sleep_request(slp));

    // ****
    // Shared tasks.
    // ****
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        int n;
        n = 0;
        @(posedge clk);
        address <= a;
        read <= !wr;
        write <= wr;
        writedata <= d;
        byteenable <= be;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        if (n >= 50) num_errors++;
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        #1;
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hf);
    endtask

    task automatic rdc(input logic [4:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, 4'hf);
        chk(q, e);
    endtask

    // Core strobes are one-cycle pulses; outputs are looked at after the sampling edge.
    task automatic pulse(input logic [5:0] m);
        @(posedge clk);
        strb <= m;
        @(posedge clk);
        strb <= 6'h00;
        #1;
    endtask

    function automatic logic [31:0] interrupt_control_state(input logic ds, input logic tk, input logic ap,
                                         input logic [5:0] hi, input logic [5:0] act);
        return {3'h0, ds, 1'b0, tk, 3'h0, ap, 4'h0, hi, 6'h00, act};
    endfunction

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // ****
    // Scenarios.
    // ****
    task automatic t_reset_values();
        rdc(IC, 32'h0);
        rdc(RC, 32'h0);
        rdc(SC, 32'h0);
        rdc(5'h00, 32'h0);
        $display("reset values done");
    endtask

    task automatic t_reset_ctrl();
        @(posedge clk) big_endian <= 1'b1;
        wr(RC, 32'h05fb_0004);
        chk(srr, 1'b0);
        wr(RC, {scb_regs_pkg::WRITE_KEY, 16'h0000});
        chk(srr, 1'b0);
        wr(RC, {scb_regs_pkg::WRITE_KEY, 16'h0004});
        chk(srr, 1'b1);
        rdc(RC, 32'h0000_8000);
        @(posedge clk) big_endian <= 1'b0;
        $display("reset control done");
    endtask

    task automatic t_sleep();
        wr(SC, 32'hffff_ffff);
        chk({woa, deep, soe}, 3'h7);
        rdc(SC, 32'h0000_0016);
        bus(1'b1, SC, 32'h0, 4'h1);
        rdc(SC, 32'h0000_0016);
        pulse(6'h20);
        chk(slp, 1'b1);
        wr(SC, 32'h0000_0004);
        chk({woa, deep, soe}, 3'h2);
        pulse(6'h20);
        chk(slp, 1'b0);
        $display("sleep control done");
    endtask

    task automatic t_pending();
        wr(IC, 32'h0400_0000);
        chk(tk_p, 1'b1);
        rdc(IC, interrupt_control_state(1'b0, 1'b1, 1'b0, 6'h0f, 6'h00));
        wr(IC, 32'h1000_0000);
        rdc(IC, interrupt_control_state(1'b1, 1'b1, 1'b0, 6'h0f, 6'h00));
        wr(IC, 32'h0200_0000);
        rdc(IC, interrupt_control_state(1'b1, 1'b0, 1'b0, 6'h0e, 6'h00));
        wr(IC, 32'h0800_0000);
        chk(ds_p, 1'b0);
        pulse(6'h01);
        chk(tk_p, 1'b1);
        pulse(6'h02);
        chk(tk_p, 1'b0);
        @(posedge clk) irq_pending <= 32'h0000_0028;
        irq_enable <= 32'h0000_0008;
        ips <= 6'h13;
        rdc(IC, interrupt_control_state(1'b0, 1'b0, 1'b1, 6'h13, 6'h13));
        @(posedge clk) irq_enable <= 32'h0;
        rdc(IC, interrupt_control_state(1'b0, 1'b0, 1'b1, 6'h00, 6'h13));
        @(posedge clk) irq_pending <= 32'h0;
        ips <= 6'h00;
        $display("pending state done");
    endtask

    task automatic t_wake();
        pulse(6'h08);
        pulse(6'h08);
        chk(waiting, 1'b1);
        @(posedge clk) irq_pending <= 32'h1;
        @(posedge clk);
        #1;
        chk({wake, waiting}, 2'h1);
        @(posedge clk) irq_pending <= 32'h3;
        irq_enable <= 32'h2;
        @(posedge clk);
        #1;
        chk(wake, 1'b1);
        pulse(6'h08);
        pulse(6'h10);
        chk(wake, 1'b1);
        pulse(6'h10);
        chk(waiting, 1'b0);
        pulse(6'h08);
        chk(wake, 1'b1);
        wr(SC, 32'h0000_0010);
        pulse(6'h08);
        @(posedge clk) irq_pending <= 32'h7;
        @(posedge clk);
        #1;
        chk(wake, 1'b1);
        $display("wake up done");
    endtask

    initial begin
        {rstn, read, write, big_endian} = 4'h0;
        {address, byteenable, writedata, strb, ips} = '0;
        {irq_pending, irq_enable, irq_prio} = '0;
        tick_prio = 2'h1;
        ds_prio = 2'h2;
        num_errors = 0;
        total_checks = 0;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        t_reset_values();
        t_reset_ctrl();
        t_sleep();
        t_pending();
        t_wake();
        wrap_up();
    end

    initial begin
        #(5 * 5000);
        num_errors++;
        wrap_up();
    end
endmodule

`default_nettype wire

// ### logic/pending_select.sv
// Picks the highest-priority pending enabled exception.
// Assumes two-bit priorities where a lower value wins and ties go
// to the lower exception number.
`timescale 1ns/10ps
`default_nettype none

module pending_select (
    // External interrupt lines.
    input  wire logic [31:0] irq_pending,
    input  wire logic [31:0] irq_enable,
    input  wire logic [63:0] irq_prio,
    // System exceptions.
    input  wire logic        tick_pending,
    input  wire logic [1:0]  tick_prio,
    input  wire logic        ds_pending,
    input  wire logic [1:0]  ds_prio,
    // Result.
    output logic      [5:0]  highest_number
);

    logic [5:0] num_chain  [0:32];
    logic [2:0] prio_chain [0:32];
    logic [5:0] start_num;
    logic [2:0] start_prio;

    // Deferred service is number 14, tick 15; the lower number wins a tie.
    assign start_num  = ds_pending ? scb_regs_pkg::EXC_DEFERRED :
                        (tick_pending ? scb_regs_pkg::EXC_TICK : 6'h00);
    assign start_prio = ds_pending ?
                        ((tick_pending && tick_prio < ds_prio) ? {1'b0, tick_prio}
                                                                : {1'b0, ds_prio}) :
                        (tick_pending ? {1'b0, tick_prio} : 3'h4);
    assign num_chain[0]  = (ds_pending && tick_pending && tick_prio < ds_prio) ?
                           scb_regs_pkg::EXC_TICK : start_num;
    assign prio_chain[0] = start_prio;

    genvar i;
    generate
        for (i = 0; i < scb_regs_pkg::NUM_IRQ; i++) begin : g_line
            logic take;
            // Strictly lower value wins, so earlier (lower) numbers keep ties.
            assign take = irq_pending[i] && irq_enable[i] &&
                          ({1'b0, irq_prio[2*i +: 2]} < prio_chain[i]);
            // Line i carries exception number i plus 16.
            assign num_chain[i+1]  = take ? (scb_regs_pkg::IRQ_BASE + 6'(i))
                                          : num_chain[i];
            assign prio_chain[i+1] = take ? {1'b0, irq_prio[2*i +: 2]}
                                          : prio_chain[i];
        end
    endgenerate

    assign highest_number = num_chain[scb_regs_pkg::NUM_IRQ];

endmodule

`default_nettype wire

// ### logic/system_control_block_regs.sv
// System control register bank: interrupt state, keyed reset control
// and low-power control, reached over an Avalon-MM slave.
// Assumes the core drives its status inputs synchronously to clk.
//
// Local design decisions: the Avalon-MM slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none

module system_control_block_regs (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        rstn,
    // Avalon-MM slave.
    input  wire logic [4:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    // Interrupt controller state.
    input  wire logic [31:0] irq_pending,
    input  wire logic [31:0] irq_enable,
    input  wire logic [63:0] irq_prio,
    input  wire logic [1:0]  tick_prio,
    input  wire logic [1:0]  ds_prio,
    // Core status and instructions.
    input  wire logic [5:0]  interrupt_program_status,
    input  wire logic        big_endian,
    input  wire logic        tick_event,
    input  wire logic        tick_taken,
    input  wire logic        ds_taken,
    input  wire logic        wait_for_event_instr,
    input  wire logic        send_event_instr,
    input  wire logic        handler_return,
    // Outputs to the core and system.
    output logic             tick_pending,
    output logic             ds_pending,
    output logic      [5:0]  highest_pending_number,
    output logic             any_irq_pending,
    output logic             system_reset_request,
    output logic             deep_low_power_select,
    output logic             sleep_after_handler_return,
    output logic             wake_on_any_pending,
    output logic             processor_wake,
    output logic             waiting_for_event,
    output logic             sleep_request
);

    // ****************************************************************
    // State.
    // ****************************************************************
    typedef enum logic {
        RUN,
        WAIT_EVENT
    } wait_state_t;

    wait_state_t wait_state_reg;
    wait_state_t wait_state_next;

    logic [31:0] readdata_reg;
    logic [31:0] readdata_next;
    logic        waitrequest_reg;

    logic        tick_pending_reg;
    logic        tick_pending_next;
    logic        ds_pending_reg;
    logic        ds_pending_next;

    logic [5:0]  active_reg;
    logic [5:0]  highest_reg;
    logic        any_pend_reg;
    logic        byte_order_reg;

    logic        sys_reset_reg;
    logic        sys_reset_next;
    logic [2:0]  sleep_ctrl_reg;
    logic [2:0]  sleep_ctrl_next;

    logic        event_latch_reg;
    logic        event_latch_next;

    logic        wake_reg;
    logic        wake_next;
    logic        sleep_req_reg;
    logic        sleep_req_next;

    logic [31:0] irq_seen_reg;
    logic        tick_seen_reg;
    logic        ds_seen_reg;

    // ****************************************************************
    // Bus decode.
    // ****************************************************************
    wire logic   access;
    wire logic   wr_commit;
    wire logic   full_word;
    wire logic   wr_int_ctrl;
    wire logic   wr_rst_ctrl;
    wire logic   wr_sleep_ctrl;
    wire logic   key_ok;

    // Waitrequest falls one cycle after a request; the write lands on the
    // edge at which the master sees it low.
    assign access        = (read || write) && waitrequest_reg;
    assign wr_commit     = write && !waitrequest_reg;
    assign full_word     = (byteenable == 4'hf);
    assign wr_int_ctrl   = wr_commit && full_word &&
                           (address == scb_regs_pkg::OFS_INT_CTRL);
    assign wr_sleep_ctrl = wr_commit && full_word &&
                           (address == scb_regs_pkg::OFS_SLEEP_CTRL);
    // A reset control write without the key in the top half is dropped whole.
    assign key_ok        = (writedata[31:scb_regs_pkg::B_KEY_LO] ==
                            scb_regs_pkg::WRITE_KEY);
    assign wr_rst_ctrl   = wr_commit && full_word && key_ok &&
                           (address == scb_regs_pkg::OFS_RST_CTRL);

    // ****************************************************************
    // Read data.
    // ****************************************************************
    wire logic [31:0] int_ctrl_view;
    wire logic [31:0] rst_ctrl_view;
    wire logic [31:0] sleep_ctrl_view;

    // Only implemented fields are placed; everything else reads zero.
    assign int_ctrl_view = {3'h0, ds_pending_reg, 1'b0,
                            tick_pending_reg,
                            3'h0,
                            any_pend_reg,
                            4'h0,
                            highest_reg,
                            6'h00,
                            active_reg};

    // Key field, reset request and the debug bit all read zero.
    assign rst_ctrl_view = {16'h0000, byte_order_reg, 15'h0000};

    assign sleep_ctrl_view = {27'h0000000,
                              sleep_ctrl_reg[2], 1'b0,
                              sleep_ctrl_reg[1], sleep_ctrl_reg[0], 1'b0};

    // Read data is loaded on the request edge.
    always_comb begin
        readdata_next = readdata_reg;
        if (access && read) begin
            unique case (address)
                scb_regs_pkg::OFS_INT_CTRL:   readdata_next = int_ctrl_view;
                scb_regs_pkg::OFS_RST_CTRL:   readdata_next = rst_ctrl_view;
                scb_regs_pkg::OFS_SLEEP_CTRL: readdata_next = sleep_ctrl_view;
                default:                      readdata_next = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            readdata_reg    <= 32'h00000000;
            waitrequest_reg <= 1'b1;
        end else begin
            readdata_reg    <= readdata_next;
            waitrequest_reg <= !access;
        end
    end

    // ****************************************************************
    // Pending flags of the system exceptions.
    // ****************************************************************
    wire logic tick_set;
    wire logic tick_clr;
    wire logic ds_set;
    wire logic ds_clr;

    assign tick_set = tick_event ||
                      (wr_int_ctrl && writedata[scb_regs_pkg::B_TICK_SET]);
    assign tick_clr = tick_taken ||
                      (wr_int_ctrl && writedata[scb_regs_pkg::B_TICK_CLR]);
    assign ds_set   = wr_int_ctrl && writedata[scb_regs_pkg::B_DS_SET];
    assign ds_clr   = ds_taken ||
                      (wr_int_ctrl && writedata[scb_regs_pkg::B_DS_CLR]);

    // Setting wins over clearing, which also settles the case of software
    // writing both bits at once.
    assign tick_pending_next = tick_set || (tick_pending_reg && !tick_clr);
    assign ds_pending_next   = ds_set || (ds_pending_reg && !ds_clr);

    always_ff @(posedge clk) begin
        if (!rstn) begin
            tick_pending_reg <= 1'b0;
            ds_pending_reg   <= 1'b0;
        end else begin
            tick_pending_reg <= tick_pending_next;
            ds_pending_reg   <= ds_pending_next;
        end
    end

    // ****************************************************************
    // Exception status.
    // ****************************************************************
    wire logic [5:0] highest_now;

    pending_select u_select (
        .irq_pending    (irq_pending),
        .irq_enable     (irq_enable),
        .irq_prio       (irq_prio),
        .tick_pending   (tick_pending_reg),
        .tick_prio      (tick_prio),
        .ds_pending     (ds_pending_reg),
        .ds_prio        (ds_prio),
        .highest_number (highest_now)
    );

    always_ff @(posedge clk) begin
        if (!rstn) begin
            active_reg     <= 6'h00;
            highest_reg    <= 6'h00;
            any_pend_reg   <= 1'b0;
            byte_order_reg <= 1'b0;
        end else begin
            active_reg     <= interrupt_program_status;
            highest_reg    <= highest_now;
            any_pend_reg   <= |irq_pending;
            byte_order_reg <= big_endian;
        end
    end

    // ****************************************************************
    // Reset and sleep control.
    // ****************************************************************
    // A zero in bit 2 leaves the request low.
    assign sys_reset_next = wr_rst_ctrl && writedata[scb_regs_pkg::B_SYS_RESET];

    // Partial writes leave the control bits alone.
    assign sleep_ctrl_next = wr_sleep_ctrl ?
                             {writedata[scb_regs_pkg::B_WAKE_ANY],
                              writedata[scb_regs_pkg::B_DEEP],
                              writedata[scb_regs_pkg::B_SLEEP_EXIT]} :
                             sleep_ctrl_reg;

    // Returning to thread mode asks for sleep only with bit 1 set.
    assign sleep_req_next = handler_return && sleep_ctrl_reg[0];

    always_ff @(posedge clk) begin
        if (!rstn) begin
            sys_reset_reg  <= 1'b0;
            sleep_ctrl_reg <= scb_regs_pkg::SLEEP_CTRL_RST;
            sleep_req_reg  <= 1'b0;
        end else begin
            sys_reset_reg  <= sys_reset_next;
            sleep_ctrl_reg <= sleep_ctrl_next;
            sleep_req_reg  <= sleep_req_next;
        end
    end

    // ****************************************************************
    // Event latch and wait-for-event wake-up.
    // ****************************************************************
    wire logic [31:0] irq_new;
    wire logic [31:0] irq_wake_mask;
    wire logic        event_now;
    wire logic        consume;

    // A pending line counts as an event only on its rising edge.
    assign irq_new = irq_pending & ~irq_seen_reg;

    // Disabled lines wake only while bit 4 is set.
    assign irq_wake_mask = sleep_ctrl_reg[2] ? 32'hffffffff : irq_enable;

    assign event_now = (|(irq_new & irq_wake_mask)) ||
                       (tick_pending_reg && !tick_seen_reg) ||
                       (ds_pending_reg && !ds_seen_reg) ||
                       send_event_instr;

    // A wait issued while waiting is ignored.
    assign consume = wait_for_event_instr && (wait_state_reg == RUN);

    always_comb begin
        wait_state_next  = wait_state_reg;
        wake_next        = 1'b0;
        event_latch_next = event_latch_reg;
        unique case (wait_state_reg)
            RUN: begin
                if (consume) begin
                    if (event_latch_reg || event_now) begin
                        // A stored event completes the wait at once.
                        wake_next        = 1'b1;
                        event_latch_next = 1'b0;
                    end else begin
                        wait_state_next = WAIT_EVENT;
                    end
                end else if (event_now) begin
                    // Not waiting, so keep it for the next wait.
                    event_latch_next = 1'b1;
                end
            end
            WAIT_EVENT: begin
                if (event_now) begin
                    wake_next       = 1'b1;
                    wait_state_next = RUN;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            wait_state_reg  <= RUN;
            event_latch_reg <= 1'b0;
            wake_reg        <= 1'b0;
            irq_seen_reg    <= 32'h00000000;
            tick_seen_reg   <= 1'b0;
            ds_seen_reg     <= 1'b0;
        end else begin
            wait_state_reg  <= wait_state_next;
            event_latch_reg <= event_latch_next;
            wake_reg        <= wake_next;
            irq_seen_reg    <= irq_pending;
            tick_seen_reg   <= tick_pending_reg;
            ds_seen_reg     <= ds_pending_reg;
        end
    end

    // ****************************************************************
    // Outputs.
    // ****************************************************************
    // Each output is a register or a bit of one.
    assign readdata                   = readdata_reg;
    assign waitrequest                = waitrequest_reg;
    assign tick_pending               = tick_pending_reg;
    assign ds_pending                 = ds_pending_reg;
    assign highest_pending_number     = highest_reg;
    assign any_irq_pending            = any_pend_reg;
    assign system_reset_request       = sys_reset_reg;
    assign deep_low_power_select      = sleep_ctrl_reg[1];
    assign sleep_after_handler_return = sleep_ctrl_reg[0];
    assign wake_on_any_pending        = sleep_ctrl_reg[2];
    assign processor_wake             = wake_reg;
    assign waiting_for_event          = (wait_state_reg == WAIT_EVENT);
    assign sleep_request              = sleep_req_reg;

endmodule

`default_nettype wire
